/* File: verilog/esbl_pkg.sv */
// Shared constants, types and helpers of the EEPROM self-boot loader
package esbl_pkg;

   // Boot memory addressing
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [15:0] IMG_BASE = 16'h0000;

   // Instruction codes
   localparam logic [7:0] OP_END = 8'h00;
   localparam logic [7:0] OP_MULTI = 8'h01;
   localparam logic [7:0] OP_DELAY = 8'h02;
   localparam logic [7:0] OP_NOP = 8'h03;
   localparam logic [7:0] OP_PLL = 8'h04;
   localparam logic [7:0] OP_SINGLE = 8'h05;
   localparam logic [15:0] MULTI_OVH = 16'h0002;

   // Check byte, x^8 + x^2 + x + 1
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;

   // Timing, in master clock cycles
   localparam int DLY_UNIT = 2048;
   localparam int DLY_SHIFT = $clog2(DLY_UNIT);
   localparam int OSC_CYC = 16568;
   localparam int RETRY_MS = 250;
   localparam int REF_KHZ = 12288;
   localparam int RETRY_CYC = RETRY_MS * REF_KHZ;
   localparam int SCL_DIV = 64;
   localparam int QTR = SCL_DIV / 4;
   localparam logic [3:0] QTR_LAST = 4'(QTR - 1);
   localparam int TMR_W = 27;

   // Bit engine commands and states
   typedef enum logic [1:0] {C_START, C_WRITE, C_READ, C_STOP} esbl_cmd_t;
   typedef enum logic [1:0] {P_IDLE, P_START, P_BITS, P_STOP} esbl_pst_t;

   // Loader states and instruction fields
   typedef enum logic [3:0] {
      S_IDLE, S_OSC, S_START, S_DEVW, S_ADRH, S_ADRL, S_RSTART, S_DEVR,
      S_READ, S_DLY, S_PLL, S_STOPR, S_RETRY, S_STOPD
   } esbl_st_t;
   typedef enum logic [3:0] {
      F_OPC, F_LENH, F_LENL, F_ADRH, F_ADRL, F_DATA, F_DLYH, F_DLYL, F_CRC
   } esbl_fld_t;

   // Internal write strobe payload
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } esbl_wr_t;

   // Bit engine state
   typedef struct packed {
      esbl_pst_t st;
      logic [3:0] div;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic rd;
      logic ack;
      logic scl_oe;
      logic sda_oe;
      logic done;
      logic nack;
   } esbl_phy_t;

   // Loader state
   typedef struct packed {
      esbl_st_t st;
      esbl_fld_t fld;
      logic pend;
      logic [TMR_W-1:0] tmr;
      logic [15:0] cnt;
      logic [15:0] tgt;
      logic [7:0] crc;
      logic pd_q;
      logic wr_valid;
      esbl_wr_t wr;
      logic busy;
      logic done;
      logic abort;
   } esbl_ctl_t;

   // One byte step of the check value
   function automatic logic [7:0] esbl_crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
      end
      return x;
   endfunction

endpackage

/* File: verilog/esbl_i2c_phy.sv */
// I2C master bit engine: start, stop, byte write and byte read
`timescale 1ns/1ns
module esbl_i2c_phy
   import esbl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Command side
   input wire logic cmd_valid,
   input wire esbl_cmd_t cmd,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_ack,
   output logic cmd_ready,
   output logic done,
   output logic [7:0] rdata,
   output logic nack,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe,
   output logic sda_oe
);

   esbl_phy_t cur;
   esbl_phy_t next_cur;
   logic tick;

   // Quarter-period sequencer, four quarters per SCL period
   always_comb begin
      next_cur = cur;
      next_cur.done = 1'b0;
      tick = cur.div == QTR_LAST;
      next_cur.div = tick ? 4'h0 : cur.div + 4'h1;
      if (tick) begin
         next_cur.ph = cur.ph + 2'h1;
      end
      unique case (cur.st)
         P_IDLE: begin
            next_cur.div = 4'h0;
            next_cur.ph = 2'h0;
            next_cur.bitn = 4'h0;
            if (cmd_valid) begin
               next_cur.sh = cmd_byte;
               next_cur.ack = cmd_ack;
               next_cur.rd = cmd == C_READ;
               next_cur.nack = 1'b0;
               unique case (cmd)
                  C_START: next_cur.st = P_START;
                  C_STOP: next_cur.st = P_STOP;
                  C_WRITE, C_READ: next_cur.st = P_BITS;
               endcase
            end
         end
         P_START: if (tick) begin
            unique case (cur.ph)
               2'h0: next_cur.sda_oe = 1'b0;
               2'h1: next_cur.scl_oe = 1'b0;
               2'h2: next_cur.sda_oe = 1'b1;
               2'h3: begin
                  next_cur.scl_oe = 1'b1;
                  next_cur.done = 1'b1;
                  next_cur.st = P_IDLE;
               end
            endcase
         end
         P_BITS: begin
            // Ack choice follows the byte as it is shifted in
            next_cur.ack = cmd_ack;
            // Slave holding SCL low stretches the low phase; the high phase starts on release
            if (cur.ph == 2'h2 && !scl_i) begin
               next_cur.div = 4'h0;
               next_cur.ph = cur.ph;
            end else if (tick) begin
               unique case (cur.ph)
                  2'h0: if (cur.bitn == 4'h8) begin
                     next_cur.sda_oe = cur.rd && cur.ack;
                  end else begin
                     next_cur.sda_oe = !cur.rd && !cur.sh[7];
                  end
                  2'h1: next_cur.scl_oe = 1'b0;
                  2'h2: if (cur.bitn == 4'h8) begin
                     next_cur.nack = !cur.rd && sda_i;
                  end else begin
                     next_cur.sh = {cur.sh[6:0], sda_i};
                  end
                  2'h3: begin
                     next_cur.scl_oe = 1'b1;
                     next_cur.bitn = cur.bitn + 4'h1;
                     if (cur.bitn == 4'h8) begin
                        next_cur.sda_oe = 1'b0;
                        next_cur.done = 1'b1;
                        next_cur.st = P_IDLE;
                     end
                  end
               endcase
            end
         end
         P_STOP: if (tick) begin
            unique case (cur.ph)
               2'h0: next_cur.sda_oe = 1'b1;
               2'h1: next_cur.scl_oe = 1'b0;
               2'h2: next_cur.sda_oe = 1'b0;
               2'h3: begin
                  next_cur.done = 1'b1;
                  next_cur.st = P_IDLE;
               end
            endcase
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs
   assign cmd_ready = cur.st == P_IDLE;
   assign done = cur.done;
   assign rdata = cur.sh;
   assign nack = cur.nack;
   assign scl_oe = cur.scl_oe;
   assign sda_oe = cur.sda_oe;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_start_edge;
      !scl_oe && $rose(sda_oe);
   endsequence

   AST_SCL_EDGE: assert property ($changed(scl_oe) |-> $past(cur.div) == QTR_LAST)
      else $error("SCL moved off a quarter boundary");
   AST_START: assert property (cmd_valid && cmd_ready && cmd == C_START
      |-> ##[1:64] s_start_edge)
      else $error("start condition not produced");

endmodule // esbl_i2c_phy

/* File: verilog/esbl_loader.sv */
// EEPROM self-boot loader top
`timescale 1ns/1ns
module esbl_loader
   import esbl_pkg::*;
#(
   parameter int OSC_WAIT_CYCLES = OSC_CYC,
   parameter int RETRY_CYCLES = RETRY_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Device pins
   input wire logic power_down_n,
   input wire logic boot_select_pin,
   input wire logic pll_locked,
   // I2C pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Internal write port
   output logic wr_valid,
   output esbl_wr_t wr,
   // Status
   output logic boot_busy,
   output logic boot_done,
   output logic boot_abort
);

   esbl_ctl_t cur;
   esbl_ctl_t next_cur;
   logic drive_lo;
   logic cmd_issue;
   logic cmd_valid;
   esbl_cmd_t cmd;
   logic [7:0] cmd_byte;
   logic cmd_ack;
   logic phy_ready;
   logic phy_done;
   logic [7:0] phy_rdata;
   logic phy_nack;
   logic fin;
   logic [7:0] b;

   // Bit engine
   esbl_i2c_phy u_phy (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .cmd_valid(cmd_valid),
      .cmd(cmd),
      .cmd_byte(cmd_byte),
      .cmd_ack(cmd_ack),
      .cmd_ready(phy_ready),
      .done(phy_done),
      .rdata(phy_rdata),
      .nack(phy_nack),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_oe(scl_oe),
      .sda_oe(sda_oe)
   );

   // Bus command for the current state
   always_comb begin
      cmd_issue = 1'b1;
      cmd = C_WRITE;
      cmd_byte = 8'h00;
      cmd_ack = 1'b0;
      unique case (cur.st)
         S_START, S_RSTART: cmd = C_START;
         S_DEVW: cmd_byte = {DEV_ADDR, 1'b0};
         S_ADRH: cmd_byte = IMG_BASE[15:8];
         S_ADRL: cmd_byte = IMG_BASE[7:0];
         S_DEVR: cmd_byte = {DEV_ADDR, 1'b1};
         S_READ: begin
            cmd = C_READ;
            // Unknown code refused on the bus, so the memory frees SDA for STOP
            cmd_ack = cur.fld != F_CRC
               && !(cur.fld == F_OPC && phy_rdata > OP_SINGLE);
         end
         S_STOPR, S_STOPD: cmd = C_STOP;
         S_IDLE, S_OSC, S_DLY, S_PLL, S_RETRY: cmd_issue = 1'b0;
      endcase
      cmd_valid = cmd_issue && !cur.pend && phy_ready && power_down_n;
      fin = cur.pend && phy_done;
      b = phy_rdata;
   end

   // Loader sequencing and instruction decode
   always_comb begin
      next_cur = cur;
      next_cur.wr_valid = 1'b0;
      next_cur.abort = 1'b0;
      next_cur.pd_q = power_down_n;
      if (cmd_valid) begin
         next_cur.pend = 1'b1;
      end
      unique case (cur.st)
         S_IDLE: ;
         S_OSC, S_RETRY: if (cur.tmr == '0) begin
            next_cur.st = S_START;
            next_cur.fld = F_OPC;
            next_cur.crc = CRC_INIT;
         end else begin
            next_cur.tmr = cur.tmr - 27'h1;
         end
         S_DLY: if (cur.tmr <= 27'h1) begin
            next_cur.st = S_READ;
         end else begin
            next_cur.tmr = cur.tmr - 27'h1;
         end
         S_PLL: if (pll_locked) begin
            next_cur.st = S_READ;
         end
         S_START, S_DEVW, S_ADRH, S_ADRL, S_RSTART, S_DEVR, S_READ, S_STOPR, S_STOPD:
         if (fin) begin
            next_cur.pend = 1'b0;
            if (phy_nack) begin
               next_cur.st = S_STOPR;
               next_cur.abort = 1'b1;
            end else begin
               unique case (cur.st)
                  S_START: next_cur.st = S_DEVW;
                  S_DEVW: next_cur.st = S_ADRH;
                  S_ADRH: next_cur.st = S_ADRL;
                  S_ADRL: next_cur.st = S_RSTART;
                  S_RSTART: next_cur.st = S_DEVR;
                  S_DEVR: next_cur.st = S_READ;
                  S_STOPR: begin
                     next_cur.st = S_RETRY;
                     next_cur.tmr = TMR_W'(RETRY_CYCLES - 1);
                  end
                  S_STOPD: begin
                     next_cur.st = S_IDLE;
                     next_cur.done = 1'b1;
                  end
                  default: begin
                     if (cur.fld != F_CRC) begin
                        next_cur.crc = esbl_crc8(cur.crc, b);
                     end
                     unique case (cur.fld)
                        F_OPC: unique case (b)
                           OP_END: next_cur.fld = F_CRC;
                           OP_MULTI: next_cur.fld = F_LENH;
                           OP_DELAY: next_cur.fld = F_DLYH;
                           OP_NOP: ;
                           OP_PLL: next_cur.st = S_PLL;
                           OP_SINGLE: begin
                              next_cur.fld = F_ADRH;
                              next_cur.cnt = 16'h0001;
                           end
                           default: begin
                              next_cur.st = S_STOPR;
                              next_cur.abort = 1'b1;
                           end
                        endcase
                        F_LENH: begin
                           next_cur.cnt[15:8] = b;
                           next_cur.fld = F_LENL;
                        end
                        F_LENL: begin
                           next_cur.cnt = ({cur.cnt[15:8], b} < MULTI_OVH) ? 16'h0000
                              : {cur.cnt[15:8], b} - MULTI_OVH;
                           next_cur.fld = F_ADRH;
                        end
                        F_ADRH: begin
                           next_cur.tgt[15:8] = b;
                           next_cur.fld = F_ADRL;
                        end
                        F_ADRL: begin
                           next_cur.tgt[7:0] = b;
                           next_cur.fld = (cur.cnt == 16'h0000) ? F_OPC : F_DATA;
                        end
                        F_DATA: begin
                           next_cur.wr_valid = 1'b1;
                           next_cur.wr = '{addr: cur.tgt, data: b};
                           next_cur.tgt = cur.tgt + 16'h0001;
                           next_cur.cnt = cur.cnt - 16'h0001;
                           if (cur.cnt == 16'h0001) begin
                              next_cur.fld = F_OPC;
                           end
                        end
                        F_DLYH: begin
                           next_cur.cnt[15:8] = b;
                           next_cur.fld = F_DLYL;
                        end
                        F_DLYL: begin
                           next_cur.tmr = {cur.cnt[15:8], b, {DLY_SHIFT{1'b0}}};
                           next_cur.fld = F_OPC;
                           if ({cur.cnt[15:8], b} != 16'h0000) begin
                              next_cur.st = S_DLY;
                           end
                        end
                        F_CRC: if (b == cur.crc) begin
                           next_cur.st = S_STOPD;
                        end else begin
                           next_cur.st = S_STOPR;
                           next_cur.abort = 1'b1;
                        end
                     endcase
                  end
               endcase
            end
         end
      endcase
      // Power-down pin acts as reset; select caught only at its release
      if (!power_down_n) begin
         next_cur.st = S_IDLE;
         next_cur.pend = 1'b0;
         next_cur.done = 1'b0;
      end else if (!cur.pd_q) begin
         next_cur.done = 1'b0;
         if (boot_select_pin) begin
            next_cur.st = S_OSC;
            next_cur.tmr = TMR_W'(OSC_WAIT_CYCLES - 1);
         end
      end
      next_cur.busy = next_cur.st != S_IDLE;
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cur <= '0;
         drive_lo <= 1'b0;
      end else begin
         cur <= next_cur;
         drive_lo <= 1'b0;
      end
   end

   // Outputs
   assign scl_o = drive_lo;
   assign sda_o = drive_lo;
   assign wr_valid = cur.wr_valid;
   assign wr = cur.wr;
   assign boot_busy = cur.busy;
   assign boot_done = cur.done;
   assign boot_abort = cur.abort;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_rep_read;
      cur.st == S_RSTART ##[1:200] cur.st == S_DEVR;
   endsequence

   AST_DEV_W: assert property (cmd_valid && cur.st == S_DEVW |-> cmd_byte == 8'ha0)
      else $error("wrong device select");
   AST_MEM_ADDR: assert property (cmd_valid && cur.st inside {S_ADRH, S_ADRL}
      |-> cmd_byte == 8'h00)
      else $error("image not fetched from zero");
   AST_RSTART: assert property (cur.st == S_ADRL && fin && !phy_nack |=> s_rep_read)
      else $error("no repeated start after address");
   AST_CRC_BAD: assert property (fin && !phy_nack && cur.st == S_READ && cur.fld == F_CRC
      && b != cur.crc && power_down_n |=> cur.st == S_STOPR && boot_abort)
      else $error("check mismatch not aborted");
   AST_BAD_OP: assert property (fin && !phy_nack && cur.st == S_READ && cur.fld == F_OPC
      && b > OP_SINGLE && power_down_n |=> cur.st == S_STOPR && boot_abort)
      else $error("unknown code not aborted");
   AST_RETRY: assert property (cur.st == S_STOPR && fin && power_down_n
      |=> cur.st == S_RETRY && cur.tmr == TMR_W'(RETRY_CYCLES - 1))
      else $error("retry delay not loaded");
   AST_WRITE: assert property (fin && !phy_nack && cur.st == S_READ && cur.fld == F_DATA
      && power_down_n |=> wr_valid && wr.data == $past(b) && wr.addr == $past(cur.tgt))
      else $error("data byte not written");
   AST_DELAY: assert property (fin && !phy_nack && cur.st == S_READ && cur.fld == F_DLYL
      && power_down_n |=> cur.tmr[TMR_W-1:DLY_SHIFT] == {$past(cur.cnt[15:8]), $past(b)})
      else $error("delay length wrong");
   AST_OSC: assert property (power_down_n && !cur.pd_q && boot_select_pin
      |=> cur.st == S_OSC && cur.tmr == TMR_W'(OSC_WAIT_CYCLES - 1))
      else $error("oscillator wait not started");
   AST_PLL: assert property (cur.st == S_PLL && !pll_locked && power_down_n
      |=> cur.st == S_PLL && !cmd_valid)
      else $error("left lock wait early");
   AST_NOSEL: assert property (power_down_n && !cur.pd_q && !boot_select_pin
      |=> cur.st == S_IDLE && !boot_busy)
      else $error("boot without select");

endmodule // esbl_loader

/* File: bench/esbl_eeprom_model.sv */
// Behavioural I2C boot memory with two-byte addressing
`timescale 1ns/1ns
module esbl_eeprom_model (
   // Bus wires
   input wire logic scl,
   input wire logic sda,
   // Data pull-down, high while driving low
   output logic sda_oe
);
   logic [7:0] mem [0:63];
   logic [7:0] devs [$];
   logic [15:0] ptr;
   logic [15:0] base;
   logic [7:0] sh;
   logic [7:0] so;
   logic act;
   logic rd;
   logic mack;
   int bitc;
   int byten;
   int n_start;

   // Idle: line released
   initial begin
      sda_oe = 1'b0;
      act = 1'b0;
      n_start = 0;
   end

   // Start or repeated start; pointer survives
   always @(negedge sda) if (scl === 1'b1) begin
      act = 1'b1;
      bitc = 0;
      byten = 0;
      rd = 1'b0;
      n_start++;
   end

   // Stop ends the transfer
   always @(posedge sda) if (scl === 1'b1) act = 1'b0;

   // Sample bits, MSB first; master ack in ninth bit
   always @(posedge scl) if (act) begin
      if (bitc < 8) sh = {sh[6:0], sda};
      else mack = ~sda;
      bitc++;
   end

   // Drive ack and read data while the clock is low
   always @(negedge scl) if (act) begin
      if (bitc == 8) begin
         if (rd && byten > 0) sda_oe = 1'b0;
         else begin
            sda_oe = (byten > 0) || (sh[7:1] == 7'h50);
            if (byten == 0) rd = sh[0];
            if (byten == 0) devs.push_back(sh);
            if (byten == 1 && !rd) ptr[15:8] = sh;
            if (byten == 2 && !rd) ptr[7:0] = sh;
            act = sda_oe;
         end
         byten++;
      end else if (bitc == 9) begin
         bitc = 0;
         sda_oe = 1'b0;
         if (rd && (byten == 1 || mack)) begin
            if (byten == 1) base = ptr;
            so = mem[ptr[5:0]];
            ptr++;
            sda_oe = ~so[7];
         end
      end else if (rd && byten > 0) sda_oe = ~so[7 - bitc];
   end
endmodule // esbl_eeprom_model

/* File: bench/testbench.sv */
// Self-checking bench of the EEPROM self-boot loader
`timescale 1ns/1ns
module testbench;
   import esbl_pkg::*;
   localparam int OSC = 200;
   localparam int RTY = 50;
   logic core_clk, rst_b, power_down_n, boot_select_pin, pll_locked;
   logic scl_o, scl_oe, sda_o, sda_oe, ee_sda_oe;
   logic wr_valid, boot_busy, boot_done, boot_abort;
   esbl_wr_t wr;
   esbl_wr_t got [$];
   logic [7:0] img [$];
   esbl_wr_t rows [4] = '{24'h1234a1, 24'h1235b2, 24'h1236c3, 24'h004077};
   logic [7:0] bad_ops [2] = '{8'h06, 8'hff};
   int n_errors = 0;
   int checked = 0;
   int n_abort = 0;
   int max_low = 0;
   int i;
   time t_rise = 0;
   time t_fall = 0;
   // Open-drain wires with pull-ups
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | ee_sda_oe);

   esbl_loader #(.OSC_WAIT_CYCLES(OSC), .RETRY_CYCLES(RTY)) dut (.core_clk(core_clk),
      .rst_b(rst_b), .power_down_n(power_down_n), .boot_select_pin(boot_select_pin),
      .pll_locked(pll_locked), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr(wr), .boot_busy(boot_busy),
      .boot_done(boot_done), .boot_abort(boot_abort));
   esbl_eeprom_model ee (.scl(scl), .sda(sda), .sda_oe(ee_sda_oe));

   // Clock, 40 ns period
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic close_out();
      $display("Counts: checked %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // Bounded wait for a flag sampled at falling edges
   task automatic wait_on(ref logic s, input int lim);
      int k;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (s !== 1'b1 && k < lim);
      if (s !== 1'b1) begin
         n_errors++;
         $display("ERROR t=%0t wait %h limit %h", $time, k, lim);
         close_out();
      end
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      repeat (8) x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
      return x;
   endfunction

   // Image into memory, erased elsewhere, check byte appended
   task automatic load(input logic bad);
      logic [7:0] c;
      c = 8'h00;
      for (int k = 0; k < 64; k++) ee.mem[k] = 8'hff;
      foreach (img[k]) begin
         ee.mem[k] = img[k];
         c = crc8(c, img[k]);
      end
      ee.mem[img.size()] = c ^ {7'h00, bad};
   endtask

   task automatic start_boot(input logic sel);
      power_down_n = 1'b0;
      got.delete();
      ee.devs.delete();
      ee.n_start = 0;
      n_abort = 0;
      max_low = 0;
      repeat (2) @(negedge core_clk);
      boot_select_pin = sel;
      power_down_n = 1'b1;
   endtask

   // Collect internal writes and aborts
   always @(negedge core_clk) begin
      if (wr_valid === 1'b1) got.push_back(wr);
      if (boot_abort === 1'b1) n_abort++;
   end

   // High phase of each bit clock is 32 master cycles
   always @(negedge scl) begin
      if (rst_b === 1'b1 && t_rise > 0 && $time - t_rise < 2000)
         chk(32'($time - t_rise), 32'd1280);
      t_fall = $time;
   end
   always @(posedge scl) begin
      if (t_fall > 0 && int'(($time - t_fall) / 40) > max_low) max_low = int'(($time - t_fall) / 40);
      t_rise = $time;
   end

   initial begin
      rst_b = 1'b0;
      power_down_n = 1'b0;
      boot_select_pin = 1'b1;
      pll_locked = 1'b1;
      img = '{8'h01, 8'h00, 8'h05, 8'h12, 8'h34, 8'ha1, 8'hb2, 8'hc3, 8'h05, 8'h00,
         8'h40, 8'h77, 8'h03, 8'h04, 8'h02, 8'h00, 8'h01, 8'h00};
      load(1'b0);
      repeat (5) @(negedge core_clk);
      chk({scl_o, sda_o, scl_oe, sda_oe, wr_valid, boot_busy, boot_done, boot_abort}, 0);
      repeat (5) @(negedge core_clk);
      rst_b = 1'b1;
      power_down_n = 1'b1;
      $display("test reset done");
      // Full boot; select dropped after release
      repeat (2) @(negedge core_clk);
      chk(boot_busy, 1);
      boot_select_pin = 1'b0;
      for (i = 0; i < 5000 && sda_oe !== 1'b1; i++) @(negedge core_clk);
      chk(i >= OSC + 46 && i <= OSC + 52, 1);
      wait_on(boot_done, 40000);
      chk(got.size(), 4);
      foreach (rows[k]) chk(got[k], rows[k]);
      chk(max_low >= 2080 && max_low <= 2200, 1);
      chk({ee.devs[0], ee.devs[1], ee.base}, 32'ha0a10000);
      chk(n_abort, 0);
      repeat (2000) @(negedge core_clk);
      chk(ee.n_start, 2);
      power_down_n = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({boot_busy, boot_done}, 0);
      $display("test boot done");
      // Lock wait holds the loader
      pll_locked = 1'b0;
      start_boot(1'b1);
      for (i = 0; i < 20000 && got.size() < 4; i++) @(negedge core_clk);
      chk(got.size(), 4);
      if (got.size() != 4) close_out();
      repeat (3000) @(negedge core_clk);
      chk({boot_busy, boot_done}, 2'b10);
      pll_locked = 1'b1;
      wait_on(boot_done, 20000);
      $display("test pll done");
      // Bad check byte: abort, then full retry
      load(1'b1);
      start_boot(1'b1);
      wait_on(boot_abort, 40000);
      chk({got.size() == 4, boot_done}, 2'b10);
      for (i = 0; i < 2000 && ee.n_start < 3; i++) @(negedge core_clk);
      chk(i >= RTY + 32 && i <= RTY + 200, 1);
      wait_on(boot_abort, 40000);
      chk(got.size(), 8);
      $display("test check byte done");
      // Unknown instruction codes
      foreach (bad_ops[k]) begin
         img = '{bad_ops[k]};
         load(1'b0);
         start_boot(1'b1);
         wait_on(boot_abort, 20000);
         chk(got.size(), 0);
      end
      $display("test bad code done");
      // Select low: no boot
      start_boot(1'b0);
      repeat (OSC + 500) @(negedge core_clk);
      chk({boot_busy, ee.n_start == 0}, 2'b01);
      $display("test no select done");
      close_out();
   end
endmodule // testbench
